// ---- gated_sixteen_bit_timer.sv ----
// Gated sixteen-bit timer/counter with prescaler, APB register slave
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "gated_timer_params.svh"

module gated_sixteen_bit_timer
  import gated_timer_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic pclk, // System oscillator clock, 250 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always one cycle
  output logic pslverr, // APB error on unmapped address
  input wire logic external_count_input, // External count pin
  input wire logic crystal_in_pin, // Crystal oscillator waveform
  input wire logic gate_input, // Gate pin
  input wire logic internal_oscillator, // Primary clock is internal osc without clock out
  input wire logic low_power_crystal_mode, // Primary clock is low-power crystal mode
  input wire logic sleep_mode, // Core is asleep
  input wire logic pin5_direction, // Pin 5 direction latch
  input wire logic pin4_direction, // Pin 4 direction latch
  input wire logic pin5_data, // Pin 5 input level
  input wire logic pin4_data, // Pin 4 input level
  output logic [1:0] pin_direction_view, // Direction bits as read, {pin5, pin4}
  output logic [1:0] pin_data_view, // Data bits as read, {pin5, pin4}
  output logic crystal_osc_run, // Crystal oscillator powered
  output logic rollover_flag, // Sticky rollover flag
  output logic wake_request // One-cycle wake pulse on rollover in sleep
);

  logic [COUNT_WIDTH-1:0] count;
  logic [7:0] control;
  logic alternate_clock_select;
  logic [2:0] ext_sync;
  logic [2:0] osc_sync;
  logic [2:0] gate_sync;
  logic ext_level;
  logic osc_level;
  logic gate_level;
  logic [1:0] phase;
  logic [2:0] prescale_count;
  logic armed;
  logic level_at_disable;
  logic counter_on_d;
  logic sync_pending;
  logic [1:0] next_pin_direction_view;
  logic [1:0] next_pin_data_view;

  // Prescale ratio minus one for a select code, used by the divider
  function automatic logic [2:0] prescale_limit(input logic [1:0] sel);
    case (sel)
      2'h0: prescale_limit = 3'h0;
      2'h1: prescale_limit = 3'h1;
      2'h2: prescale_limit = 3'h3;
      2'h3: prescale_limit = 3'h7;
      default: prescale_limit = 3'h0;
    endcase
  endfunction

  // APB decode
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_low = (paddr == `OFS_COUNT_LOW);
  wire hit_high = (paddr == `OFS_COUNT_HIGH);
  wire hit_control = (paddr == `OFS_CONTROL);
  wire hit_aux = (paddr == `OFS_AUX);
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_pins = (paddr == `OFS_PIN_VIEW);
  wire mapped = hit_low | hit_high | hit_control | hit_aux | hit_status | hit_pins;
  wire write_low = wr & hit_low;
  wire write_high = wr & hit_high;
  wire count_write = write_low | write_high;
  wire flag_clear = wr & hit_status & pwdata[`STS_ROLLOVER];

  // Control fields
  wire counter_on = control[`CTL_COUNTER_ON];
  wire clock_source_select = control[`CTL_CLOCK_SOURCE];
  wire external_sync_disable = control[`CTL_SYNC_DISABLE];
  wire crystal_osc_enable = control[`CTL_OSC_ENABLE];
  wire [1:0] prescale_select = control[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
  wire gate_enable = control[`CTL_GATE_ENABLE];
  wire gate_invert = control[`CTL_GATE_INVERT];

  // Crystal shares the system low-power oscillator
  wire osc_usable = internal_oscillator | low_power_crystal_mode;
  wire osc_active = crystal_osc_enable & osc_usable;
  wire use_crystal = osc_active & internal_oscillator;

  wire clock_source_type source = clock_source_select ? src_external :
    (alternate_clock_select ? src_full : src_quarter);

  // Three-stage sampling; a level counts once stages two and three agree
  wire ext_next = use_crystal ? osc_level : ext_level;
  wire ext_settled = (ext_sync[1] == ext_sync[2]);
  wire osc_settled = (osc_sync[1] == osc_sync[2]);
  wire gate_settled = (gate_sync[1] == gate_sync[2]);
  wire ext_new = ext_settled ? ext_sync[2] : ext_level;
  wire osc_new = osc_settled ? osc_sync[2] : osc_level;
  wire pin_rise = ext_new & ~ext_level;
  wire pin_fall = ~ext_new & ext_level;
  wire osc_rise = osc_new & ~osc_level;
  wire osc_fall = ~osc_new & osc_level;
  wire src_rise = use_crystal ? osc_rise : pin_rise;
  wire src_fall = use_crystal ? osc_fall : pin_fall;
  wire src_level = use_crystal ? osc_level : ext_level;

  // Gate polarity: invert set means active high
  wire gate_open = ~gate_enable | (gate_level == gate_invert);
  wire run = counter_on & gate_open;

  // Instruction cycle boundary every fourth oscillator clock
  wire instr_tick = (phase == `PHASE_LAST);

  // Synchronized mode waits for the phase boundary and stops in sleep; the
  // asynchronous path counts at once and keeps running in sleep
  wire ext_edge = src_rise & armed;
  wire sync_tick = (ext_edge | sync_pending) & instr_tick & ~sleep_mode;
  wire async_tick = ext_edge;
  wire ext_tick = external_sync_disable ? async_tick : sync_tick;

  logic source_tick;
  always_comb begin
    case (source)
      src_quarter: source_tick = instr_tick & ~sleep_mode;
      src_full: source_tick = ~sleep_mode;
      src_external: source_tick = ext_tick;
      default: source_tick = 1'b0;
    endcase
  end

  wire step = run & source_tick;
  wire prescale_done = (prescale_count == prescale_limit(prescale_select));
  wire increment = step & prescale_done;
  // Whole-word add keeps the byte carry inside one increment
  wire [COUNT_WIDTH:0] count_sum = {1'b0, count} + {{COUNT_WIDTH{1'b0}}, 1'b1};
  wire rollover = increment & count_sum[COUNT_WIDTH];
  wire enable_rise = counter_on & ~counter_on_d;

  // Register read mux
  wire [31:0] status_word = {29'h0000000, armed, osc_usable, rollover_flag};
  wire [31:0] read_word = hit_low ? {24'h000000, count[7:0]} :
    hit_high ? {24'h000000, count[15:8]} :
    hit_control ? {24'h000000, control} :
    hit_aux ? {31'h00000000, alternate_clock_select} :
    hit_status ? status_word :
    hit_pins ? {28'h0000000, pin_data_view, pin_direction_view} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign crystal_osc_run = osc_active;

  // Direction reads 1 and data reads 0 while the oscillator owns the pins
  always_comb begin
    next_pin_direction_view = {pin5_direction, pin4_direction};
    next_pin_data_view = {pin5_data, pin4_data};
    if (crystal_osc_enable) begin
      next_pin_direction_view = 2'h3;
      next_pin_data_view = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= read_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `CONTROL_RESET;
      alternate_clock_select <= `AUX_RESET;
    end else begin
      if (wr & hit_control) begin
        control <= pwdata[7:0];
      end
      if (wr & hit_aux) begin
        alternate_clock_select <= pwdata[`AUX_ALT_CLOCK];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync <= 3'h0;
      osc_sync <= 3'h0;
      gate_sync <= 3'h0;
      ext_level <= 1'b0;
      osc_level <= 1'b0;
      gate_level <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], external_count_input};
      osc_sync <= {osc_sync[1:0], crystal_in_pin & osc_active};
      gate_sync <= {gate_sync[1:0], gate_input};
      ext_level <= ext_new;
      osc_level <= osc_new;
      if (gate_settled) begin
        gate_level <= gate_sync[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Re-arm: a falling edge must be seen before the first counted rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      level_at_disable <= 1'b0;
      counter_on_d <= 1'b0;
    end else begin
      counter_on_d <= counter_on;
      if (counter_on_d & ~counter_on) begin
        level_at_disable <= src_level;
      end
      if (count_write) begin
        armed <= 1'b0;
      end else if (enable_rise & level_at_disable & ~src_level) begin
        armed <= 1'b0;
      end else if (counter_on & src_fall) begin
        armed <= 1'b1;
      end
    end
  end

  // A pending synchronized edge is dropped on a switch to asynchronous mode,
  // which is where one increment may go missing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_pending <= 1'b0;
    end else if (external_sync_disable | count_write | ~run) begin
      sync_pending <= 1'b0;
    end else if (instr_tick & ~sleep_mode) begin
      sync_pending <= 1'b0;
    end else if (ext_edge) begin
      sync_pending <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= `PRESCALE_ZERO;
    end else if (count_write) begin
      prescale_count <= `PRESCALE_ZERO;
    end else if (step) begin
      prescale_count <= prescale_done ? `PRESCALE_ZERO : prescale_count + 3'h1;
    end
  end

  // Byte writes go straight into the live count and beat an increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `COUNT_RESET;
    end else if (count_write) begin
      if (write_low) begin
        count[7:0] <= pwdata[7:0];
      end
      if (write_high) begin
        count[15:8] <= pwdata[7:0];
      end
    end else if (increment) begin
      count <= count_sum[COUNT_WIDTH-1:0];
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rollover_flag <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      if (rollover) begin
        rollover_flag <= 1'b1;
      end else if (flag_clear) begin
        rollover_flag <= 1'b0;
      end
      wake_request <= rollover & sleep_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_view <= 2'h3;
      pin_data_view <= 2'h0;
    end else begin
      pin_direction_view <= next_pin_direction_view;
      pin_data_view <= next_pin_data_view;
    end
  end

endmodule

// ---- gated_timer_params.svh ----
// Register map, field positions and reset values of the gated sixteen-bit timer
`ifndef GATED_TIMER_PARAMS_SVH
`define GATED_TIMER_PARAMS_SVH

`define OFS_COUNT_LOW 8'h00
`define OFS_COUNT_HIGH 8'h04
`define OFS_CONTROL 8'h08
`define OFS_AUX 8'h0C
`define OFS_STATUS 8'h10
`define OFS_PIN_VIEW 8'h14

`define CTL_COUNTER_ON 0
`define CTL_CLOCK_SOURCE 1
`define CTL_SYNC_DISABLE 2
`define CTL_OSC_ENABLE 3
`define CTL_PRESCALE_LO 4
`define CTL_PRESCALE_HI 5
`define CTL_GATE_ENABLE 6
`define CTL_GATE_INVERT 7
`define AUX_ALT_CLOCK 0
`define STS_ROLLOVER 0
`define STS_OSC_USABLE 1
`define STS_ARMED 2

`define CONTROL_RESET 8'h00
`define AUX_RESET 1'h0
`define COUNT_RESET 16'h0000
`define PHASE_LAST 2'h3
`define PRESCALE_ZERO 3'h0

`endif

// ---- gated_timer_pkg.sv ----
// Types shared by the gated sixteen-bit timer
package gated_timer_pkg;
  // Gray coded along quarter, full rate, external pin
  typedef enum logic [1:0] {
    src_quarter = 2'h0,
    src_full = 2'h1,
    src_external = 2'h3
  } clock_source_type;
endpackage

// ---- gated_timer_monitor.sv ----
// Port-level assertions for the gated sixteen-bit timer
`timescale 1ns/10ps
`include "gated_timer_params.svh"
module gated_timer_monitor (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic internal_oscillator, // Strap
  input wire logic low_power_crystal_mode, // Strap
  input wire logic sleep_mode, // Sleep
  input wire logic pin5_direction, // Dir 5
  input wire logic pin4_direction, // Dir 4
  input wire logic pin5_data, // Data 5
  input wire logic pin4_data, // Data 4
  input wire logic [1:0] pin_direction_view, // Dir view
  input wire logic [1:0] pin_data_view, // Data view
  input wire logic crystal_osc_run, // Osc power
  input wire logic rollover_flag, // Flag
  input wire logic wake_request // Wake
);
  logic [7:0] ctl;
  wire acc = psel && penable;
  wire rd_ctl = acc && !pwrite && paddr == `OFS_CONTROL;
  wire rd_sts = acc && !pwrite && paddr == `OFS_STATUS;
  wire clr = acc && pwrite && paddr == `OFS_STATUS && pwdata[0];
  wire mapped = paddr inside {`OFS_COUNT_LOW, `OFS_COUNT_HIGH, `OFS_CONTROL, `OFS_AUX,
    `OFS_STATUS, `OFS_PIN_VIEW};
  // Shadow of the control register, kept from the bus alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctl <= 8'h00;
    else if (acc && pwrite && paddr == `OFS_CONTROL)
      ctl <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; acc |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_run;
    crystal_osc_run == (ctl[3] && (internal_oscillator || low_power_crystal_mode));
  endproperty
  a_run: assert property (p_run) else $error("osc run wrong");
  property p_force; ctl[3] |=> pin_direction_view == 2'h3 && pin_data_view == 2'h0; endproperty
  a_force: assert property (p_force) else $error("pin view not forced");
  property p_follow;
    !ctl[3] |=> pin_direction_view == $past({pin5_direction, pin4_direction})
      && pin_data_view == $past({pin5_data, pin4_data});
  endproperty
  a_follow: assert property (p_follow) else $error("pin view stale");
  property p_clear; $fell(rollover_flag) |-> $past(clr); endproperty
  a_clear: assert property (p_clear) else $error("flag fell alone");
  property p_wake; wake_request |-> rollover_flag && $past(sleep_mode) ##1 !wake_request; endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_rdctl; rd_ctl |-> prdata[7:0] == ctl; endproperty
  a_rdctl: assert property (p_rdctl) else $error("control readback");
  property p_rdflag; rd_sts |-> prdata[0] == $past(rollover_flag); endproperty
  a_rdflag: assert property (p_rdflag) else $error("flag readback");
  property p_still; !ctl[0] && !$past(ctl[0]) && !$past(ctl[0], 2) |-> !$rose(rollover_flag);
  endproperty
  a_still: assert property (p_still) else $error("rolled while off");
  c_wake: cover property (wake_request);
  c_roll: cover property ($rose(rollover_flag));
  c_err: cover property (pslverr);
endmodule

// ---- pulse_source.sv ----
// Behavioural external pulse source for the count and crystal pins
`timescale 1ns/10ps
module pulse_source (
  input wire logic pclk, // Bench clock
  input wire logic go, // Start a burst
  input wire logic [7:0] pulses, // Pulses per burst
  input wire logic [3:0] half, // Half period in cycles
  output logic pin, // Pulse line, low at rest
  output logic busy // Burst running
);
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Line stands low between bursts, so every burst opens with a rise
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      repeat (pulses) begin
        repeat (half) @(posedge pclk);
        pin <= 1'b1;
        repeat (half) @(posedge pclk);
        pin <= 1'b0;
      end
      repeat (half) @(posedge pclk);
      busy <= 1'b0;
    end
  end
endmodule

// ---- tb_gated_sixteen_bit_timer.sv ----
// Self-checking bench for the gated sixteen-bit timer
`timescale 1ns/10ps
`include "gated_timer_params.svh"
module tb_gated_sixteen_bit_timer;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, gate_input, sleep_mode, go;
  logic internal_oscillator, low_power_crystal_mode;
  logic pin5_direction, pin4_direction, pin5_data, pin4_data;
  logic [7:0] paddr, pulses;
  logic [3:0] half;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, crystal_osc_run, rollover_flag, wake_request, busy;
  logic [1:0] pin_direction_view, pin_data_view;
  wire external_count_input, crystal_in_pin;
  int fails = 0, checked = 0, cyc = 0, wakes = 0, t0, r, n;
  int unsigned seed = 81;
  assign crystal_in_pin = external_count_input;
  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  always @(posedge pclk) if (wake_request === 1'b1) wakes <= wakes + 1;
  gated_sixteen_bit_timer uut (.*);
  pulse_source src (.pclk(pclk), .go(go), .pulses(pulses), .half(half),
    .pin(external_count_input), .busy(busy));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Phase and gate sampling leave a few cycles of slack in a span
  task automatic chk_span(input int got, input int exp);
    checked++;
    if (got < exp - 8 || got > exp + 8) begin
      fails++;
      $display("ERROR t=%0t span %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic burst(input int k);
    pulses <= k[7:0];
    half <= 4'h3 + k[1:0];
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1) @(posedge pclk);
    repeat (10) @(posedge pclk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, go, gate_input, sleep_mode, low_power_crystal_mode} = 7'h00;
    {pin5_direction, pin4_direction, pin5_data, pin4_data} = 4'h0;
    internal_oscillator = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    pulses = 8'h00;
    half = 4'h4;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CONTROL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = 1 << i[1:0];
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b1, `OFS_AUX, {31'h0, i[2]});
      apb(1'b1, `OFS_COUNT_LOW, 32'hF0);
      apb(1'b1, `OFS_COUNT_HIGH, 32'hFF);
      apb(1'b1, `OFS_STATUS, 32'h1);
      gate_input <= !i[0];
      apb(1'b1, `OFS_CONTROL, {24'h0, i[0], 1'b1, i[1:0], 4'h1});
      repeat (40) @(posedge pclk);
      gate_input <= i[0];
      t0 = cyc;
      while (rollover_flag !== 1'b1 && cyc - t0 < 3000) @(posedge pclk);
      chk_span(cyc - t0, 16 * r * (i[2] ? 1 : 4));
      apb(1'b0, `OFS_COUNT_HIGH, 32'h0);
      chk(q & 32'hFF, 32'h0);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(q & 32'h1, 32'h1);
      apb(1'b1, `OFS_STATUS, 32'h1);
      chk({31'h0, rollover_flag}, 32'h0);
    end
    $display("test internal done");
    for (int m = 0; m < 8; m++) begin
      r = 1 << m[2:1];
      n = rnd();
      {pin5_direction, pin4_direction, pin5_data, pin4_data} <= n[3:0];
      // The crystal gets its start-up time before the counter is switched on
      if (m == 7) begin
        apb(1'b1, `OFS_CONTROL, {26'h0, m[2:1], 1'b1, m[0], 2'h2});
        repeat (50) @(posedge pclk);
      end
      apb(1'b1, `OFS_CONTROL, {26'h0, m[2:1], m == 7, m[0], 2'h3});
      apb(1'b1, `OFS_COUNT_LOW, 32'h0);
      apb(1'b1, `OFS_COUNT_HIGH, 32'h0);
      n = 2 + rnd() % 15;
      burst(n);
      apb(1'b0, `OFS_COUNT_LOW, 32'h0);
      chk(q & 32'hFF, (n - 1) / r);
      apb(1'b0, `OFS_PIN_VIEW, 32'h0);
      chk(q & 32'hF, m == 7 ? 32'h3 :
        {28'h0, pin5_data, pin4_data, pin5_direction, pin4_direction});
    end
    $display("test external done");
    apb(1'b1, `OFS_STATUS, 32'h1);
    apb(1'b1, `OFS_CONTROL, 32'h7);
    apb(1'b1, `OFS_COUNT_LOW, 32'hFE);
    apb(1'b1, `OFS_COUNT_HIGH, 32'hFF);
    t0 = wakes;
    sleep_mode <= 1'b1;
    burst(3);
    sleep_mode <= 1'b0;
    chk(wakes - t0, 32'h1);
    chk({31'h0, rollover_flag}, 32'h1);
    $display("test sleep done");
    close_out();
  end
endmodule
bind gated_sixteen_bit_timer gated_timer_monitor mon (.*);
